// File: verilog/pin_cond_pkg.sv
// Register map, field masks and reset values of the serial pin conditioning.
package pin_cond_pkg;
    localparam int              ADDR_W            = 20;
    localparam int              DATA_W            = 16;
    localparam int              BYTE_W            = 8;
    localparam int              TX_CH             = 4;
    localparam int              RX_CH             = 4;
    localparam int              FIELD_STRIDE      = 2;
    localparam int              UART3_IDX         = 3;
    localparam logic [19:0]     ADDR_P0_BUF       = 20'hf0040;
    localparam logic [19:0]     ADDR_P1_BUF       = 20'hf0041;
    localparam logic [19:0]     ADDR_P14_BUF      = 20'hf004e;
    localparam logic [19:0]     ADDR_NFEN         = 20'hf0060;
    localparam logic [19:0]     ADDR_INV_U0       = 20'hf0134;
    localparam logic [19:0]     ADDR_INV_U1       = 20'hf0174;
    localparam logic [19:0]     ADDR_ROUTE        = 20'hfff3c;
    localparam logic [15:0]     SOL_MASK          = 16'h0005;
    localparam logic [15:0]     SOL_RESET         = 16'h0000;
    localparam logic [7:0]      ROUTE_MASK        = 8'h03;
    localparam logic [7:0]      NFEN_MASK         = 8'h55;
    localparam logic [7:0]      P0_BUF_MASK       = 8'h18;
    localparam logic [7:0]      P1_BUF_MASK       = 8'h03;
    localparam logic [7:0]      P14_BUF_MASK      = 8'h0c;
    localparam logic [7:0]      BYTE_RESET        = 8'h00;
    localparam int              ROUTE_EXT_INT_BIT = 0;
    localparam int              ROUTE_TIMER_BIT   = 1;
endpackage : pin_cond_pkg

// File: verilog/rx_filter_if.sv
// Receive lines, filter enables and filtered levels between the modules.
`timescale 1ns/100ps
interface rx_filter_if #(parameter int CH = 4);
    logic [CH-1:0] raw;
    logic [CH-1:0] en;
    logic [CH-1:0] filtered;
    modport filt (input raw, input en, output filtered);
    modport ctrl (output raw, output en, input filtered);
endinterface : rx_filter_if

// File: verilog/rx_noise_filter.sv
// Per-channel receive noise filter with two-sample match detection.
`timescale 1ns/100ps
module rx_noise_filter #(
    parameter int CH = 4
) (
    input  wire logic   clk,
    input  wire logic   rst_n,
    rx_filter_if.filt   fif
);
    logic [CH-1:0] sync1;
    logic [CH-1:0] sync2;
    logic [CH-1:0] prev;
    logic [CH-1:0] level;

    assign fif.filtered = level;

    genvar k;
    generate
        for (k = 0; k < CH; k++)
        begin : g_ch
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    sync1[k] <= 1'b0;
                    sync2[k] <= 1'b0;
                    prev[k]  <= 1'b0;
                end
                else
                begin
                    sync1[k] <= fif.raw[k];
                    sync2[k] <= sync1[k];
                    prev[k]  <= sync2[k];
                end
            end

            // With the filter enabled, a glitch shorter than one clock never reaches the level; a disabled channel passes the raw pin.
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                    level[k] <= 1'b0;
                else if (!fif.en[k])
                    level[k] <= fif.raw[k];
                else if (sync2[k] == prev[k])
                    level[k] <= sync2[k];
            end

            chk_filter_match: assert property (
                @(posedge clk) disable iff (!rst_n)
                (fif.en[k] && $past(fif.en[k]) && $changed(level[k]))
                |-> ($past(sync2[k]) == $past(prev[k]))
            ) else $error("Filtered level changed without two matching samples.");

            chk_filter_bypass: assert property (
                @(posedge clk) disable iff (!rst_n)
                !fif.en[k] |=> level[k] == $past(fif.raw[k])
            ) else $error("Disabled filter did not pass the raw level.");
        end
    endgenerate
endmodule : rx_noise_filter

// File: verilog/serial_pin_conditioning_regs.sv
// Serial pin conditioning registers: tx invert, rx routing, filters, buffers.
`timescale 1ns/100ps
module serial_pin_conditioning_regs
    import pin_cond_pkg::*;
(
    // Clock and reset.
    input  wire logic                            CORE_CLK_I,
    input  wire logic                            RST_N_I,
    // CPU register access.
    input  wire logic [pin_cond_pkg::ADDR_W-1:0] ADDR_I,
    input  wire logic [pin_cond_pkg::DATA_W-1:0] WDATA_I,
    input  wire logic                            WR_I,
    input  wire logic                            RD_I,
    input  wire logic                            WORD_I,
    output      logic [pin_cond_pkg::DATA_W-1:0] RDATA_O,
    // Transmit side, order unit1 ch2, unit1 ch0, unit0 ch2, unit0 ch0.
    input  wire logic [pin_cond_pkg::TX_CH-1:0]  TX_DATA_I,
    input  wire logic [pin_cond_pkg::TX_CH-1:0]  SERIAL_OUT_EN_I,
    input  wire logic [pin_cond_pkg::TX_CH-1:0]  SERIAL_OUT_VAL_I,
    output      logic [pin_cond_pkg::TX_CH-1:0]  TX_PIN_O,
    // Receive side, channels 3 to 0.
    input  wire logic [pin_cond_pkg::RX_CH-1:0]  RX_PIN_I,
    output      logic [pin_cond_pkg::RX_CH-1:0]  RX_DATA_O,
    // Interrupt and timer input routing.
    input  wire logic                            EXT_INT0_PIN_I,
    input  wire logic                            TIMER_CH7_PIN_I,
    output      logic                            EXT_INT0_O,
    output      logic                            TIMER_CH7_O,
    // Input buffer type selects, 1 selects TTL.
    output      logic [7:0]                      PORT0_TTL_SEL_O,
    output      logic [7:0]                      PORT1_TTL_SEL_O,
    output      logic [7:0]                      PORT14_TTL_SEL_O
);
    import pin_cond_pkg::*;

    logic [15:0]      tx_level_invert_unit0;
    logic [15:0]      tx_level_invert_unit1;
    logic [7:0]       rx_input_routing;
    logic [7:0]       rx_noise_filter_enable;
    logic [7:0]       port0_input_buffer_select;
    logic [7:0]       port1_input_buffer_select;
    logic [7:0]       port14_input_buffer_select;
    logic [TX_CH-1:0] tx_invert_bit;
    logic [TX_CH-1:0] next_tx_pin;
    logic [15:0]      wr_word;
    logic [7:0]       wr_byte;
    logic [15:0]      rd_mux;
    logic             hit_inv0;
    logic             hit_inv1;
    logic             hit_route;
    logic             hit_nfen;
    logic             hit_buf0;
    logic             hit_buf1;
    logic             hit_buf14;
    logic             hit_any;
    logic             uart3_line;
    logic             next_ext_int0;
    logic             next_timer_ch7;

    rx_filter_if #(.CH(RX_CH)) fif ();

    rx_noise_filter #(.CH(RX_CH)) u_filter (
        .clk   (CORE_CLK_I),
        .rst_n (RST_N_I),
        .fif   (fif)
    );

    // Address decode; a byte access only ever reaches the low byte.
    assign hit_inv0  = ADDR_I == ADDR_INV_U0;
    assign hit_inv1  = ADDR_I == ADDR_INV_U1;
    assign hit_route = ADDR_I == ADDR_ROUTE;
    assign hit_nfen  = ADDR_I == ADDR_NFEN;
    assign hit_buf0  = ADDR_I == ADDR_P0_BUF;
    assign hit_buf1  = ADDR_I == ADDR_P1_BUF;
    assign hit_buf14 = ADDR_I == ADDR_P14_BUF;
    assign hit_any   = hit_inv0 | hit_inv1 | hit_route | hit_nfen
                     | hit_buf0 | hit_buf1 | hit_buf14;
    assign wr_byte   = WDATA_I[BYTE_W-1:0];
    assign wr_word   = {WORD_I ? WDATA_I[DATA_W-1:BYTE_W] : BYTE_RESET,
                        wr_byte};

    assign rd_mux = hit_inv0  ? tx_level_invert_unit0 :
                    hit_inv1  ? tx_level_invert_unit1 :
                    hit_route ? {BYTE_RESET, rx_input_routing} :
                    hit_nfen  ? {BYTE_RESET, rx_noise_filter_enable} :
                    hit_buf0  ? {BYTE_RESET, port0_input_buffer_select} :
                    hit_buf1  ? {BYTE_RESET, port1_input_buffer_select} :
                    hit_buf14 ? {BYTE_RESET, port14_input_buffer_select} :
                    16'h0000;

    // Masks on write keep absent bits at zero, so reads see zero there.
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            tx_level_invert_unit0      <= SOL_RESET;
            tx_level_invert_unit1      <= SOL_RESET;
            rx_input_routing           <= BYTE_RESET;
            rx_noise_filter_enable     <= BYTE_RESET;
            port0_input_buffer_select  <= BYTE_RESET;
            port1_input_buffer_select  <= BYTE_RESET;
            port14_input_buffer_select <= BYTE_RESET;
        end
        else if (WR_I)
        begin
            if (hit_inv0)
                tx_level_invert_unit0 <= wr_word & SOL_MASK;
            if (hit_inv1)
                tx_level_invert_unit1 <= wr_word & SOL_MASK;
            if (hit_route)
                rx_input_routing <= wr_byte & ROUTE_MASK;
            if (hit_nfen)
                rx_noise_filter_enable <= wr_byte & NFEN_MASK;
            if (hit_buf0)
                port0_input_buffer_select <= wr_byte & P0_BUF_MASK;
            if (hit_buf1)
                port1_input_buffer_select <= wr_byte & P1_BUF_MASK;
            if (hit_buf14)
                port14_input_buffer_select <= wr_byte & P14_BUF_MASK;
        end
    end

    // Read data is held until the next read so software sees a stable value.
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            RDATA_O <= 16'h0000;
        else if (RD_I)
            RDATA_O <= rd_mux;
    end

    // Channel pairs per unit sit at invert bits 0 and 2.
    genvar k;
    generate
        for (k = 0; k < TX_CH; k++)
        begin : g_tx
            if (k < FIELD_STRIDE)
            begin : g_u0
                assign tx_invert_bit[k] =
                    tx_level_invert_unit0[k * FIELD_STRIDE];
            end
            else
            begin : g_u1
                assign tx_invert_bit[k] =
                    tx_level_invert_unit1[(k - FIELD_STRIDE) * FIELD_STRIDE];
            end
            assign next_tx_pin[k] = SERIAL_OUT_EN_I[k]
                ? (TX_DATA_I[k] ^ tx_invert_bit[k])
                : SERIAL_OUT_VAL_I[k];
        end
        for (k = 0; k < RX_CH; k++)
        begin : g_rx
            assign fif.en[k] = rx_noise_filter_enable[k * FIELD_STRIDE];
        end
    endgenerate

    assign fif.raw        = RX_PIN_I;
    assign uart3_line     = fif.filtered[UART3_IDX];
    assign next_ext_int0  = rx_input_routing[ROUTE_EXT_INT_BIT]
                          ? uart3_line : EXT_INT0_PIN_I;
    assign next_timer_ch7 = rx_input_routing[ROUTE_TIMER_BIT]
                          ? uart3_line : TIMER_CH7_PIN_I;

    // Every pin-facing output is re-timed here, costing one clock of latency.
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            TX_PIN_O         <= '0;
            RX_DATA_O        <= '0;
            EXT_INT0_O       <= 1'b0;
            TIMER_CH7_O      <= 1'b0;
            PORT0_TTL_SEL_O  <= BYTE_RESET;
            PORT1_TTL_SEL_O  <= BYTE_RESET;
            PORT14_TTL_SEL_O <= BYTE_RESET;
        end
        else
        begin
            TX_PIN_O         <= next_tx_pin;
            RX_DATA_O        <= fif.filtered;
            EXT_INT0_O       <= next_ext_int0;
            TIMER_CH7_O      <= next_timer_ch7;
            PORT0_TTL_SEL_O  <= port0_input_buffer_select;
            PORT1_TTL_SEL_O  <= port1_input_buffer_select;
            PORT14_TTL_SEL_O <= port14_input_buffer_select;
        end
    end

    chk_tx_inverted_out: assert property (
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (SERIAL_OUT_EN_I[0] && tx_level_invert_unit0[0])
        |=> TX_PIN_O[0] == !$past(TX_DATA_I[0])
    ) else $error("Enabled inverted channel did not drive inverted data.");

    chk_tx_plain_out: assert property (
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (SERIAL_OUT_EN_I[3] && !tx_level_invert_unit1[2])
        |=> TX_PIN_O[3] == $past(TX_DATA_I[3])
    ) else $error("Non-inverted channel altered transmit data.");

    chk_tx_disabled_value: assert property (
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        !SERIAL_OUT_EN_I[1] |=> TX_PIN_O[1] == $past(SERIAL_OUT_VAL_I[1])
    ) else $error("Disabled output did not show the stored value.");

    chk_tx_invert_u1: assert property (
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (SERIAL_OUT_EN_I[2] && tx_level_invert_unit1[0])
        |=> TX_PIN_O[2] == !$past(TX_DATA_I[2])
    ) else $error("Inverted unit 1 channel did not drive inverted data.");

    chk_tx_gated_off: assert property (
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (!SERIAL_OUT_EN_I[3] && tx_level_invert_unit1[2])
        |=> TX_PIN_O[3] == $past(SERIAL_OUT_VAL_I[3])
    ) else $error("Inversion reached a pin whose output is disabled.");

    chk_sol_byte_write: assert property (
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (WR_I && hit_inv1)
        |=> tx_level_invert_unit1 == {13'h0, $past(WDATA_I[2]),
                                      1'b0, $past(WDATA_I[0])}
    ) else $error("Invert register write did not store bits 2 and 0.");

    chk_sol_word_write: assert property (
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (WR_I && WORD_I && hit_inv0)
        |=> tx_level_invert_unit0 == ($past(WDATA_I) & SOL_MASK)
    ) else $error("Word write to the invert register was not stored.");

    chk_sol_reserved_zero: assert property (
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        ((tx_level_invert_unit0 | tx_level_invert_unit1) & ~SOL_MASK) == '0
    ) else $error("Unimplemented invert bit became set.");

    chk_route_ext_int: assert property (
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        rx_input_routing[ROUTE_EXT_INT_BIT]
        |=> EXT_INT0_O == $past(fif.filtered[UART3_IDX])
    ) else $error("External interrupt input not taken from UART3 line.");

    chk_route_ext_pin: assert property (
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        !rx_input_routing[ROUTE_EXT_INT_BIT]
        |=> EXT_INT0_O == $past(EXT_INT0_PIN_I)
    ) else $error("External interrupt input not taken from its own pin.");

    chk_route_timer: assert property (
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        !rx_input_routing[ROUTE_TIMER_BIT]
        |=> TIMER_CH7_O == $past(TIMER_CH7_PIN_I)
    ) else $error("Timer channel 7 input not taken from its own pin.");

    chk_route_timer_rx: assert property (
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        rx_input_routing[ROUTE_TIMER_BIT]
        |=> TIMER_CH7_O == $past(fif.filtered[UART3_IDX])
    ) else $error("Timer channel 7 input not taken from UART3 line.");

    chk_route_reserved: assert property (
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (rx_input_routing & ~ROUTE_MASK) == '0
        && (rx_noise_filter_enable & ~NFEN_MASK) == '0
    ) else $error("Unimplemented routing or filter bit became set.");

    chk_rx_data_copy: assert property (
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        RX_DATA_O == $past(fif.filtered)
    ) else $error("Receive output did not follow the filtered level.");

    chk_pim_layout: assert property (
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (PORT0_TTL_SEL_O & ~P0_BUF_MASK) == '0
        && (PORT1_TTL_SEL_O & ~P1_BUF_MASK) == '0
        && (PORT14_TTL_SEL_O & ~P14_BUF_MASK) == '0
    ) else $error("Input buffer select shows an unimplemented bit.");

    chk_buf_select_copy: assert property (
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        PORT0_TTL_SEL_O == $past(port0_input_buffer_select)
        && PORT1_TTL_SEL_O == $past(port1_input_buffer_select)
        && PORT14_TTL_SEL_O == $past(port14_input_buffer_select)
    ) else $error("Input buffer select output lost its register value.");

    chk_unmapped_read: assert property (
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (RD_I && !hit_any) |=> RDATA_O == 16'h0000
    ) else $error("Unmapped read returned nonzero data.");
endmodule : serial_pin_conditioning_regs

// File: dv/lin_pin_model.sv
// Transceiver side model driving the receive, wake and timer pins.
`timescale 1ns/100ps
module lin_pin_model (
    // Clock and pace.
    input  wire logic       clk_i,
    input  wire logic       slow_i,
    // Pin levels.
    output      logic [3:0] rx_o,
    output      logic       ext_o,
    output      logic       tim_o
);
    integer     seed = 88797;
    int         cnt  = 0;
    logic [3:0] lvl  = 4'h0;
    initial {rx_o, ext_o, tim_o} = 6'h00;
    // Slow pace holds each bit for eight cycles; one-cycle spikes come at either pace,
    // so the filter meets real edges as well as noise it has to reject.
    always @(posedge clk_i)
    begin
        cnt <= cnt + 1;
        if (!slow_i || cnt % 8 == 0)
            lvl <= 4'($random(seed));
        rx_o <= (($random(seed) & 7) == 0) ? ~lvl : lvl;
        ext_o <= 1'($random(seed));
        tim_o <= 1'($random(seed));
    end
endmodule : lin_pin_model

// File: dv/tb.sv
// Self-checking bench of the serial pin conditioning registers.
`timescale 1ns/100ps
module tb;
    import pin_cond_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [19:0] addr = 20'h00000;
    logic [15:0] wdata = 16'h0000;
    logic        wr_s = 1'b0;
    logic        rd_s = 1'b0;
    logic        word = 1'b0;
    logic        slow = 1'b0;
    logic [3:0]  txd = 4'h0;
    logic [3:0]  oen = 4'h0;
    logic [3:0]  oval = 4'h0;
    logic [15:0] rdata;
    logic [3:0]  txp, rxp, rxo, s1, s2, pv, lvl, e_rx, e_tx;
    logic        ext_pin, tim_pin, ext_o, tim_o, e_ext, e_tim;
    logic [7:0]  ttl0, ttl1, ttl14;
    logic [15:0] shadow [7] = '{default: 16'h0000};
    logic [19:0] map [7] = '{ADDR_P0_BUF, ADDR_P1_BUF, ADDR_P14_BUF,
                             ADDR_NFEN, ADDR_INV_U0, ADDR_INV_U1,
                             ADDR_ROUTE};
    logic [15:0] msk [7] = '{16'(P0_BUF_MASK), 16'(P1_BUF_MASK),
                             16'(P14_BUF_MASK), 16'(NFEN_MASK), SOL_MASK,
                             SOL_MASK, 16'(ROUTE_MASK)};
    integer      seed = 88797;
    int          bad_count = 0;
    int          num_checks = 0;
    time         quiet = 0;
    wire logic [3:0] inv = {shadow[5][2], shadow[5][0],
                            shadow[4][2], shadow[4][0]};
    wire logic [3:0] nfe = {shadow[3][6], shadow[3][4],
                            shadow[3][2], shadow[3][0]};
    wire logic [3:0] fil = lvl;

    always #25 clk = ~clk;

    serial_pin_conditioning_regs u_serial_pin_conditioning_regs (
        .CORE_CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr_s), .RD_I(rd_s), .WORD_I(word), .RDATA_O(rdata),
        .TX_DATA_I(txd), .SERIAL_OUT_EN_I(oen), .SERIAL_OUT_VAL_I(oval),
        .TX_PIN_O(txp), .RX_PIN_I(rxp), .RX_DATA_O(rxo),
        .EXT_INT0_PIN_I(ext_pin), .TIMER_CH7_PIN_I(tim_pin),
        .EXT_INT0_O(ext_o), .TIMER_CH7_O(tim_o), .PORT0_TTL_SEL_O(ttl0),
        .PORT1_TTL_SEL_O(ttl1), .PORT14_TTL_SEL_O(ttl14));

    lin_pin_model u_lin_pin_model (
        .clk_i(clk), .slow_i(slow), .rx_o(rxp), .ext_o(ext_pin),
        .tim_o(tim_pin));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : check

    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : test_done

    function automatic logic [15:0] exp_rd(input logic [19:0] a);
        for (int i = 0; i < 7; i++)
            if (map[i] == a)
                return shadow[i];
        return 16'h0000;
    endfunction : exp_rd

    task automatic bus_wr(input logic [19:0] a, input logic [15:0] d,
                          input logic w);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        word <= w;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
        quiet = $time + 500;
        for (int i = 0; i < 7; i++)
            if (map[i] == a)
                shadow[i] <= d & msk[i];
    endtask : bus_wr

    task automatic bus_rd(input logic [19:0] a, output logic [15:0] v);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 v = rdata;
    endtask : bus_rd

    // Holding reset for eight cycles, then every place must read zero.
    task automatic reset_check;
        logic [15:0] v;
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        shadow = '{default: 16'h0000};
        quiet = $time + 500;
        for (int i = 0; i < 9; i++)
        begin
            bus_rd((i < 7) ? map[i] : (i == 7) ? 20'hf0135 : 20'hf0061, v);
            check(v, 16'h0000);
        end
        $display("test reset values done");
    endtask : reset_check

    // Reference pipeline: two sync stages, a previous sample, then a level
    // that only moves when two samples agree, or follows the pin when its filter is off.
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            {s1, s2, pv, lvl, e_rx, e_tx, e_ext, e_tim} <= '0;
        else
        begin
            s1 <= rxp;
            s2 <= s1;
            pv <= s2;
            lvl <= (~nfe & rxp) | (nfe & ~(s2 ^ pv) & s2)
                 | (nfe & (s2 ^ pv) & lvl);
            e_rx <= fil;
            e_tx <= (oen & (txd ^ inv)) | (~oen & oval);
            e_ext <= shadow[6][0] ? fil[3] : ext_pin;
            e_tim <= shadow[6][1] ? fil[3] : tim_pin;
        end
    end

    always @(posedge clk)
    begin
        txd <= 4'($random(seed));
        oen <= 4'($random(seed));
        oval <= 4'($random(seed));
    end

    // Register changes need a few cycles to settle through the pipeline.
    always @(negedge clk)
        if (rst_n && $time > quiet)
        begin
            check(txp, e_tx);
            check(rxo, e_rx);
            check(ext_o, e_ext);
            check(tim_o, e_tim);
            check({ttl0, ttl1}, {shadow[0][7:0], shadow[1][7:0]});
            check(ttl14, shadow[2][7:0]);
        end

    initial
    begin
        #(50 * 20000);
        bad_count++;
        test_done();
    end

    initial
    begin
        logic [15:0] v;
        int          j;
        reset_check();
        for (int i = 0; i < 9; i++)
            bus_wr((i < 7) ? map[i] : (i == 7) ? 20'hf0135 : 20'hf0061,
                   16'hffff, 1'b1);
        bus_wr(ADDR_INV_U1, 16'hff01, 1'b0);
        for (int i = 0; i < 7; i++)
        begin
            bus_rd(map[i], v);
            check(v, exp_rd(map[i]));
        end
        $display("test masks and byte access done");
        repeat (40)
        begin
            j = $unsigned($random(seed)) % 7;
            slow <= ~slow;
            bus_wr(map[j], 16'($random(seed)) & msk[j], 1'($random(seed)));
            repeat (30) @(posedge clk);
            bus_rd(map[j], v);
            check(v, exp_rd(map[j]));
        end
        $display("test random traffic done");
        slow <= 1'b1;
        bus_wr(ADDR_NFEN, 16'h0055, 1'b0);
        bus_wr(ADDR_ROUTE, 16'h0003, 1'b0);
        bus_wr(ADDR_INV_U0, 16'h0005, 1'b1);
        repeat (300) @(posedge clk);
        bus_wr(ADDR_ROUTE, 16'h0000, 1'b0);
        repeat (100) @(posedge clk);
        $display("test filtered wake routing done");
        reset_check();
        test_done();
    end
endmodule : tb
